//--- rtl/quad_rate_burst4_sram_port.sv
// Four-word burst double data rate static memory, separate read and write ports.
// Assumes CLK_IN oversamples the input clock pair by at least four per half period.
// Summary of operation
// R1 - Read and write addresses alternate on one bus
// R2 - Each location holds four sequential burst words
// R3 - Words move on both input clock rising edges
// R4 - Latency pin high: two and half cycles
// R5 - Latency pin low: one cycle read latency
// R6 - Read and write ports run independently
// R7 - Data valid output marks valid read words
// R8 - Free-running echo clock pair drives out
// R9 - All synchronous inputs pass input registers
// R10 - Data outputs launched from output registers
// R11 - Captured write completes internally, self-timed
// R12 - Separate select inputs for each port
// R13 - Reads return the most recent written data
// R14 - Write select low starts write; high ignores
// R15 - Write data sampled only during active writes
// R16 - Read select low starts four-word read
module quad_rate_burst4_sram_port
   import qrb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF
) (
   input  wire logic                     CLK_IN,
   input  wire logic                     RST_IN,
   input  wire logic                     K_IN,
   input  wire logic                     K_N_IN,
   input  wire logic                     READ_SELECT_N_IN,
   input  wire logic                     WRITE_SELECT_N_IN,
   input  wire logic                     LATENCY_MODE_SELECT_IN,
   input  wire logic [ADDR_W-1:0]        ADDR_IN,
   input  wire logic [DATA_W/BYTE_W-1:0] BYTE_WRITE_SELECT_N_IN,
   input  wire logic [DATA_W-1:0]        D_IN,
   output logic      [DATA_W-1:0]        Q_OUT,
   output logic                          READ_DATA_VALID_OUT,
   output logic                          ECHO_CLOCK_OUT,
   output logic                          ECHO_CLOCK_N_OUT
);
   localparam int BW_W = DATA_W / BYTE_W;
   localparam int SW   = 5 + ADDR_W + BW_W + DATA_W;

   if (!(DATA_W == DATA_W_DEF || DATA_W == DATA_W_WIDE)) begin : g_bad_width
      $error("DATA_W must be 18 or 36");
   end
   if (ADDR_W < 1) begin : g_bad_addr
      $error("ADDR_W must be at least 1");
   end

   logic [SW-1:0]     pins_raw;
   logic [SW-1:0]     pins_sync;
   logic              k_s;
   logic              kn_s;
   logic              rd_n_s;
   logic              wr_n_s;
   logic              lat_hi_s;
   logic [ADDR_W-1:0] addr_s;
   logic [BW_W-1:0]   bw_n_s;
   logic [DATA_W-1:0] d_s;
   logic              k_d;
   logic              kn_d;
   logic [2:0]        fill;
   logic              k_rise;
   logic              kn_rise;
   logic              beat;
   slot_e             slot;
   logic              rd_req;
   logic              wr_start;
   wr_state_e         wr_state;
   logic [1:0]        wr_cnt;
   logic              wr_commit;
   logic [ADDR_W-1:0] wbuf_addr;
   logic [3:0]        wcol;
   logic [DATA_W-1:0] wdat [BURST_LEN];
   logic [BW_W-1:0]   wbw  [BURST_LEN];
   logic [DATA_W-1:0] mem  [2**(ADDR_W+2)];
   rd_slot_s          pipe [PIPE_D];
   logic [ADDR_W-1:0] pipe_addr [PIPE_D];
   logic [2:0]        ld_base;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] fwd_word;
   logic              fwd_full;

   function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [BW_W-1:0]   bw_n);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int b = 0; b < BW_W; b++) begin
         if (!bw_n[b]) begin
            res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
         end
      end
      return res;
   endfunction : merge_bytes

   // Every pin, the clock pair included, is resynchronised as one bundle
   assign pins_raw = {K_IN, K_N_IN, READ_SELECT_N_IN, WRITE_SELECT_N_IN,
                      LATENCY_MODE_SELECT_IN, ADDR_IN, BYTE_WRITE_SELECT_N_IN, D_IN};

   sync_stage2 #(.W(SW)) u_pin_sync (                   // R9
      .CLK_IN   (CLK_IN),
      .RST_IN   (RST_IN),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   assign {k_s, kn_s, rd_n_s, wr_n_s, lat_hi_s, addr_s, bw_n_s, d_s} = pins_sync;

   // Echo pair runs with the input pair; edges wait for real samples, not reset zeros
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         fill             <= '0;
         k_d              <= 1'b0;
         kn_d             <= 1'b0;
         ECHO_CLOCK_OUT   <= 1'b0;
         ECHO_CLOCK_N_OUT <= 1'b0;
      end else begin
         fill             <= {fill[1:0], 1'b1};
         k_d              <= k_s;
         kn_d             <= kn_s;
         ECHO_CLOCK_OUT   <= k_s;                       // R8
         ECHO_CLOCK_N_OUT <= kn_s;
      end
   end

   assign k_rise  = fill[2] & k_s & ~k_d;
   assign kn_rise = fill[2] & kn_s & ~kn_d;
   assign beat    = k_rise | kn_rise;                    // R3

   // Slot order after reset starts with a read address
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         slot <= SLOT_READ;
      end else if (k_rise) begin
         slot <= (slot == SLOT_READ) ? SLOT_WRITE : SLOT_READ; // R1
      end
   end

   assign rd_req   = k_rise && (slot == SLOT_READ) && !rd_n_s;   // R12 R16
   assign wr_start = k_rise && (slot == SLOT_WRITE) && !wr_n_s   // R12 R14
                     && (wr_state == WR_IDLE);

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wr_state <= WR_IDLE;
         wr_cnt   <= FIRST_WORD;
      end else if (beat) begin
         case (wr_state)
            WR_IDLE: begin
               if (wr_start) begin                      // R14
                  wr_state <= WR_BURST;
                  wr_cnt   <= SECOND_WORD;
               end
            end
            WR_BURST: begin
               if (wr_cnt == LAST_WORD) begin            // R2
                  wr_state <= WR_IDLE;
               end
               wr_cnt <= wr_cnt + SECOND_WORD;
            end
            default: begin
               wr_state <= WR_IDLE;
            end
         endcase
      end
   end

   // Words land only while a write burst is open
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wbuf_addr <= '0;
         wcol      <= '0;
         for (int w = 0; w < BURST_LEN; w++) begin
            wdat[w] <= '0;
            wbw[w]  <= '1;
         end
      end else if (wr_start) begin
         wbuf_addr        <= addr_s;
         wcol             <= FIRST_COL;
         wdat[FIRST_WORD] <= d_s;                       // R15
         wbw[FIRST_WORD]  <= bw_n_s;
      end else if (beat && (wr_state == WR_BURST)) begin
         wdat[wr_cnt] <= d_s;                           // R15
         wbw[wr_cnt]  <= bw_n_s;
         wcol[wr_cnt] <= 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wr_commit <= 1'b0;
      end else begin
         wr_commit <= beat && (wr_state == WR_BURST) && (wr_cnt == LAST_WORD); // R11
      end
   end

   // Array holds data only, so it carries no reset
   always_ff @(posedge CLK_IN) begin
      if (wr_commit) begin
         for (int w = 0; w < BURST_LEN; w++) begin
            mem[{wbuf_addr, 2'(w)}] <= merge_bytes(mem[{wbuf_addr, 2'(w)}],
                                                   wdat[w], wbw[w]); // R11 R2
         end
      end
   end

   // Fetch at launch time so late write words are still seen
   assign fwd_word = wdat[pipe[0].idx];
   assign fwd_full = (wbuf_addr == pipe_addr[0]) && wcol[pipe[0].idx]
                     && (wbw[pipe[0].idx] == '0);

   always_comb begin
      rd_word = mem[{pipe_addr[0], pipe[0].idx}];
      if ((wbuf_addr == pipe_addr[0]) && wcol[pipe[0].idx]) begin
         rd_word = merge_bytes(rd_word, fwd_word, wbw[pipe[0].idx]); // R13
      end
   end

   assign ld_base = (lat_hi_s ? LAT_BEATS_HI : LAT_BEATS_LO) - LAT_OFFSET; // R4 R5

   // Beat-indexed launch schedule; the write side never touches it
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int k = 0; k < PIPE_D; k++) begin
            pipe[k]      <= '0;
            pipe_addr[k] <= '0;
         end
      end else if (beat) begin
         for (int k = 0; k < PIPE_D - 1; k++) begin
            pipe[k]      <= pipe[k+1];
            pipe_addr[k] <= pipe_addr[k+1];
         end
         pipe[PIPE_D-1] <= '0;
         if (rd_req) begin
            for (int j = 0; j < BURST_LEN; j++) begin
               pipe[ld_base + 3'(j)]      <= '{vld: 1'b1, idx: 2'(j)}; // R16 R6
               pipe_addr[ld_base + 3'(j)] <= addr_s;
            end
         end
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         Q_OUT               <= '0;
         READ_DATA_VALID_OUT <= 1'b0;
      end else if (beat) begin
         Q_OUT               <= pipe[0].vld ? rd_word : '0; // R10 R3
         READ_DATA_VALID_OUT <= pipe[0].vld;                // R7
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence last_word_s;
      beat && (wr_state == WR_BURST) && (wr_cnt == LAST_WORD);
   endsequence

   sequence commit_s;
      wr_commit ##1 !wr_commit;
   endsequence

   slot_alt_a: assert property (k_rise |=> slot != $past(slot)) // R1
      else $error("address slot did not alternate");

   write_burst_a: assert property (last_word_s |=> commit_s ##0 (wr_state == WR_IDLE)) // R2
      else $error("write burst not closed after four words");

   quiet_out_a: assert property (!beat |=> $stable(Q_OUT) && $stable(READ_DATA_VALID_OUT)) // R10
      else $error("read output changed off a beat");

   lat_high_a: assert property (rd_req && lat_hi_s |=> pipe[4].vld && pipe[4].idx == 2'h0
                                && pipe[7].vld && pipe[7].idx == 2'h3) // R4
      else $error("long latency schedule wrong");

   lat_low_a: assert property (rd_req && !lat_hi_s |=> pipe[1].vld && pipe[1].idx == 2'h0
                               && pipe[4].vld && pipe[4].idx == 2'h3) // R5
      else $error("short latency schedule wrong");

   valid_beat_a: assert property ($rose(READ_DATA_VALID_OUT) |-> $past(beat)) // R7
      else $error("data valid rose off a beat");

   echo_follow_a: assert property ($rose(k_s) |=> ECHO_CLOCK_OUT ##1 ECHO_CLOCK_OUT) // R8
      else $error("echo clock did not follow input clock");

   write_ignore_a: assert property (k_rise && slot == SLOT_WRITE && wr_n_s
                                    && wr_state == WR_IDLE |=> wr_state == WR_IDLE) // R14
      else $error("deselected write port started a burst");

   read_idle_a: assert property (beat && !rd_req |=> !pipe[PIPE_D-1].vld) // R16
      else $error("read scheduled without a select");

   forward_a: assert property (beat && pipe[0].vld && fwd_full
                               |=> Q_OUT == $past(fwd_word)) // R13
      else $error("read missed the latest written word");

endmodule : quad_rate_burst4_sram_port

//--- rtl/qrb_pkg.sv
// Constants and types for the four-word burst static memory port.
// Assumes one system clock that oversamples the memory's input clock pair.
package qrb_pkg;

   localparam int       BURST_LEN    = 4;
   localparam int       BYTE_W       = 9;
   localparam int       DATA_W_DEF   = 18;
   localparam int       DATA_W_WIDE  = 36;
   // Flip-flop array, so the default depth is kept small
   localparam int       ADDR_W_DEF   = 8;
   localparam int       PIPE_D       = 8;
   localparam logic [2:0] LAT_BEATS_HI = 3'h5;
   localparam logic [2:0] LAT_BEATS_LO = 3'h2;
   localparam logic [2:0] LAT_OFFSET   = 3'h1;
   localparam logic [1:0] FIRST_WORD   = 2'h0;
   localparam logic [1:0] SECOND_WORD  = 2'h1;
   localparam logic [1:0] LAST_WORD    = 2'h3;
   localparam logic [3:0] FIRST_COL    = 4'h1;

   typedef enum logic [1:0] {
      SLOT_READ  = 2'b01,
      SLOT_WRITE = 2'b10
   } slot_e;

   typedef enum logic [1:0] {
      WR_IDLE  = 2'b01,
      WR_BURST = 2'b10
   } wr_state_e;

   typedef struct packed {
      logic       vld;
      logic [1:0] idx;
   } rd_slot_s;

endpackage : qrb_pkg

//--- rtl/sync_stage2.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is quasi-static around the sampling edge.
module sync_stage2 #(
   parameter int W = 1
) (
   input  wire logic         CLK_IN,
   input  wire logic         RST_IN,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta;

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : sync_stage2

//--- bench/mem_ctrl_model.sv
// Memory controller model: input clock pair, selects, address, write data.
// Assumes the bench fills the beat tables before each call of run.
module mem_ctrl_model
   import qrb_pkg::*;
#(
   parameter int DATA_W = DATA_W_DEF,
   parameter int NB     = 44
) (
   output logic                      k_out,
   output logic                      k_n_out,
   output logic                      rsel_n_out,
   output logic                      wsel_n_out,
   output logic [ADDR_W_DEF-1:0]     addr_out,
   output logic [DATA_W-1:0]         d_out,
   output logic [DATA_W/BYTE_W-1:0]  bws_n_out,
   input  wire logic [DATA_W-1:0]    q_in,
   input  wire logic                 vld_in,
   input  wire logic                 echo_in,
   input  wire logic                 echo_n_in
);
   timeunit 1ns;
   timeprecision 100ps;

   logic                     rs_n   [NB];
   logic                     ws_n   [NB];
   logic [ADDR_W_DEF-1:0]    ad     [NB];
   logic [DATA_W-1:0]        dt     [NB];
   logic [DATA_W/BYTE_W-1:0] bw     [NB];
   logic [DATA_W-1:0]        q_seen [NB];
   logic                     v_seen [NB];
   logic [1:0]               e_seen [NB];

   initial begin
      k_out = 1'b0;
      k_n_out = 1'b1;
      rsel_n_out = 1'b1;
      wsel_n_out = 1'b1;
      addr_out = '0;
      d_out = '0;
      bws_n_out = '1;
   end

   task automatic clear();
      for (int b = 0; b < NB; b++) begin
         // Each select low in the other port's slot, so slot alternation matters
         rs_n[b] = ~b[1];
         ws_n[b] = b[1];
         // Busy lines change every beat, never parked at the last value
         ad[b] = ~b[7:0];
         dt[b] = DATA_W'(b * 37) ^ '1;
         bw[b] = (DATA_W/BYTE_W)'(b);
      end
   endtask : clear

   // One half period of K a step; inputs move midway, away from both edges
   task automatic run();
      for (int k = 0; k < NB; k++) begin
         rsel_n_out = rs_n[k];
         wsel_n_out = ws_n[k];
         addr_out = ad[k];
         d_out = dt[k];
         bws_n_out = bw[k];
         #14;
         if (k > 0) begin
            q_seen[k-1] = q_in;
            v_seen[k-1] = vld_in;
            e_seen[k-1] = {echo_in, echo_n_in};
         end
         #2;
         k_out = ~k[0];
         k_n_out = k[0];
         #16;
      end
   endtask : run
endmodule : mem_ctrl_model

//--- bench/quad_rate_burst4_sram_port_bench.sv
// Self-checking bench: a table of bursts run in both latency modes.
// Assumes qrb_pkg, the design and mem_ctrl_model are compiled first.
module quad_rate_burst4_sram_port_bench;
   import qrb_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int NB = 44;
   typedef struct packed {
      logic        wr;
      logic [3:0]  slot;
      logic [7:0]  addr;
      logic [17:0] base;
      logic [1:0]  bws_n;
   } op_s;
   // Slot s: read request at beat 4s, write request at beat 4s+2
   localparam op_s ROWS [10] = '{
      '{1'b1, 4'h0, 8'h11, 18'h01000, 2'h0},
      '{1'b1, 4'h1, 8'h22, 18'h02000, 2'h0},
      '{1'b1, 4'h2, 8'hff, 18'h03000, 2'h0},
      '{1'b0, 4'h2, 8'hff, 18'h00000, 2'h0},
      '{1'b1, 4'h3, 8'h22, 18'h00abc, 2'h1},
      '{1'b0, 4'h3, 8'h11, 18'h00000, 2'h0},
      '{1'b0, 4'h4, 8'h22, 18'h00000, 2'h0},
      '{1'b1, 4'h4, 8'h11, 18'h3ffff, 2'h3},
      '{1'b0, 4'h5, 8'h22, 18'h00000, 2'h0},
      '{1'b0, 4'h6, 8'h11, 18'h00000, 2'h0}
   };

   logic                 CLK_IN;
   logic                 RST_IN;
   logic                 LATENCY_MODE_SELECT_IN;
   logic                 k;
   logic                 k_n;
   logic                 rsel_n;
   logic                 wsel_n;
   logic [7:0]           addr;
   logic [17:0]          d;
   logic [1:0]           bws_n;
   logic [17:0]          q;
   logic                 vld;
   logic                 echo;
   logic                 echo_n;
   logic [17:0]          mem   [1024];
   logic [17:0]          exp_q [NB];
   logic                 exp_v [NB];
   int                   miscompares;
   int                   check_count;

   initial begin
      CLK_IN = 1'b0;
      RST_IN = 1'b1;
      LATENCY_MODE_SELECT_IN = 1'b1;
      miscompares = 0;
      check_count = 0;
   end
   always #2.5 CLK_IN = ~CLK_IN;

   quad_rate_burst4_sram_port u_quad_rate_burst4_sram_port (
      .CLK_IN                 (CLK_IN),
      .RST_IN                 (RST_IN),
      .K_IN                   (k),
      .K_N_IN                 (k_n),
      .READ_SELECT_N_IN       (rsel_n),
      .WRITE_SELECT_N_IN      (wsel_n),
      .LATENCY_MODE_SELECT_IN (LATENCY_MODE_SELECT_IN),
      .ADDR_IN                (addr),
      .BYTE_WRITE_SELECT_N_IN (bws_n),
      .D_IN                   (d),
      .Q_OUT                  (q),
      .READ_DATA_VALID_OUT    (vld),
      .ECHO_CLOCK_OUT         (echo),
      .ECHO_CLOCK_N_OUT       (echo_n)
   );

   mem_ctrl_model #(.NB(NB)) u_mem_ctrl_model (
      .k_out      (k),
      .k_n_out    (k_n),
      .rsel_n_out (rsel_n),
      .wsel_n_out (wsel_n),
      .addr_out   (addr),
      .d_out      (d),
      .bws_n_out  (bws_n),
      .q_in       (q),
      .vld_in     (vld),
      .echo_in    (echo),
      .echo_n_in  (echo_n)
   );

   task automatic check_word(input logic [17:0] got, input logic [17:0] want);
      check_count++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t: read word %h, expected %h", $time, got, want);
      end
   endtask : check_word

   task automatic check_bit(input logic got, input logic want);
      check_count++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t: flag %b, expected %b", $time, got, want);
      end
   endtask : check_bit

   // Fill the beat tables, then replay them in beat order for expectations
   task automatic plan_run(input int lat);
      int         b;
      int         wb;
      int         r;
      logic [7:0] wa;
      u_mem_ctrl_model.clear();
      for (int i = 0; i < $size(ROWS); i++) begin
         b = 4 * ROWS[i].slot + (ROWS[i].wr ? 2 : 0);
         u_mem_ctrl_model.ad[b] = ROWS[i].addr;
         if (ROWS[i].wr) begin
            u_mem_ctrl_model.ws_n[b] = 1'b0;
            for (int j = 0; j < 4; j++) begin
               u_mem_ctrl_model.dt[b+j] = ROWS[i].base + 18'(j);
               u_mem_ctrl_model.bw[b+j] = ROWS[i].bws_n;
            end
         end else begin
            u_mem_ctrl_model.rs_n[b] = 1'b0;
         end
      end
      foreach (exp_v[i]) begin
         exp_v[i] = 1'b0;
         exp_q[i] = '0;
      end
      wb = -8;
      for (int t = 0; t < NB; t++) begin
         // Each read word is fetched at its launch beat, before a word landing then
         for (int j = 0; j < 4; j++) begin
            r = t - lat - j;
            if (r >= 0 && r % 4 == 0 && u_mem_ctrl_model.rs_n[r] == 1'b0) begin
               exp_v[t] = 1'b1;
               exp_q[t] = mem[{u_mem_ctrl_model.ad[r], 2'(j)}];
            end
         end
         if (t % 4 == 2 && u_mem_ctrl_model.ws_n[t] == 1'b0) begin
            wb = t;
            wa = u_mem_ctrl_model.ad[t];
         end
         if (t - wb < 4) begin
            for (int y = 0; y < 2; y++) begin
               if (!u_mem_ctrl_model.bw[t][y]) begin
                  mem[{wa, 2'(t - wb)}][9*y +: 9] = u_mem_ctrl_model.dt[t][9*y +: 9];
               end
            end
         end
      end
   endtask : plan_run

   task automatic run_mode(input logic mode);
      @(posedge CLK_IN);
      #1;
      RST_IN = 1'b1;
      LATENCY_MODE_SELECT_IN = mode;
      plan_run(mode ? int'(LAT_BEATS_HI) : int'(LAT_BEATS_LO));
      repeat (16) @(posedge CLK_IN);
      #1;
      check_bit(vld, 1'b0);
      check_word(q, '0);
      RST_IN = 1'b0;
      u_mem_ctrl_model.run();
      for (int t = 0; t < NB - 1; t++) begin
         check_word(u_mem_ctrl_model.q_seen[t], exp_q[t]);
         check_bit(u_mem_ctrl_model.v_seen[t], exp_v[t]);
         check_bit(u_mem_ctrl_model.e_seen[t][1], ~t[0]);
         check_bit(u_mem_ctrl_model.e_seen[t][0], t[0]);
      end
   endtask : run_mode

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // Two runs take about 3 us; far more means a hang
   initial begin
      #20us;
      miscompares++;
      $display("ERROR %0t: watchdog expired", $time);
      summarize();
   end

   // Reset between runs also checks that the array survives it
   initial begin
      run_mode(1'b1);
      run_mode(1'b0);
      summarize();
   end
endmodule : quad_rate_burst4_sram_port_bench
